// ===== hw/pfl_pkg.sv
package pfl_pkg;
  localparam int          ADDR_W        = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ENABLE    = 8'hCF;
  localparam logic [7:0]  IDX_CONTROL   = 8'hD2;
  localparam logic [7:0]  IDX_PER_LO    = 8'hD3;
  localparam logic [7:0]  IDX_PER_HI    = 8'hD4;
  localparam logic [7:0]  IDX_DUTY_LO   = 8'hD5;
  localparam logic [7:0]  IDX_DUTY_HI   = 8'hD6;
  localparam logic [7:0]  IDX_LOCK      = 8'hE7;
  localparam logic [7:0]  IDX_GIEN      = 8'hE8;
  localparam logic [7:0]  LOCK_KEY      = 8'h55;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  // Field positions
  localparam int          EN_FAULT_BIT  = 6;
  localparam int          CTL_IE_BIT    = 7;
  localparam int          CTL_IF_BIT    = 6;
  localparam int          CTL_FS_BIT    = 4;
  localparam int          CTL_FP_BIT    = 3;
  localparam int          CTL_POL_BIT   = 2;
  // Cycles from enable write to waveform on the pin
  localparam int          EN_DELAY_CYC  = 3;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } pfl_apb_req_t;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] drive;
  } pfl_pins_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Prescaler mask: 1, 3, 7, 15 for /2, /4, /8, /16
  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    return 4'(({1'b0, 4'h2} << sel) - 5'h01);
  endfunction
endpackage

// ===== hw/pfl_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module pfl_top
  import pfl_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire pfl_apb_req_t apb_req,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic         fault_pin,
  input  wire logic [1:0]   sub_wave,
  input  wire logic [1:0]   sub_irq,
  output pfl_pins_t         pins,
  output logic              fault_sel,
  output logic              irq
);
  // Register state
  logic [6:0]  en_r;
  logic        ie_r, if_r, fs_r, fp_r, pol_r;
  logic [1:0]  clk_r;
  logic [11:0] per_r, duty_r;
  logic [7:0]  lock_r;
  logic        gien_r;
  // Period-boundary shadows and counters
  logic [11:0] per_a, duty_a, cnt_r, cnt_nxt;
  logic        pol_a;
  logic [1:0]  clk_a;
  logic [3:0]  pre_r;
  logic        hold_r, fs_nxt, if_nxt, hold_nxt;
  logic [5:0]  en_d1, en_d2;
  logic        pready_r, pslverr_r, fault_sel_r, irq_r;
  logic [31:0] prdata_r;
  pfl_pins_t   pins_r, pins_nxt;

  // Bus decode
  wire         setup    = apb_req.psel & ~apb_req.penable;
  wire         wr       = apb_req.psel & apb_req.penable & pready_r & apb_req.pwrite;
  wire [7:0]   wdat     = apb_req.pwdata[7:0];
  wire         unlocked = (lock_r == LOCK_KEY);
  wire         hit_en   = apb_req.paddr == reg_addr(IDX_ENABLE);
  wire         hit_ctl  = apb_req.paddr == reg_addr(IDX_CONTROL);
  wire         hit_pl   = apb_req.paddr == reg_addr(IDX_PER_LO);
  wire         hit_ph   = apb_req.paddr == reg_addr(IDX_PER_HI);
  wire         hit_dl   = apb_req.paddr == reg_addr(IDX_DUTY_LO);
  wire         hit_dh   = apb_req.paddr == reg_addr(IDX_DUTY_HI);
  wire         hit_lk   = apb_req.paddr == reg_addr(IDX_LOCK);
  wire         hit_ge   = apb_req.paddr == reg_addr(IDX_GIEN);
  wire         mapped   = hit_en | hit_ctl | hit_pl | hit_ph | hit_dl | hit_dh | hit_lk | hit_ge;
  wire         wr_g     = wr & unlocked;
  wire         wr_ctl   = wr_g & hit_ctl;
  wire [7:0]   ctl_rd   = {ie_r, if_r, 1'b0, fs_r, fp_r, pol_r, clk_r};
  wire [7:0]   rd_mux   = hit_en  ? {1'b0, en_r} :
                          hit_ctl ? ctl_rd :
                          hit_pl  ? per_r[7:0] :
                          hit_ph  ? {4'h0, per_r[11:8]} :
                          hit_dl  ? duty_r[7:0] :
                          hit_dh  ? {4'h0, duty_r[11:8]} :
                          hit_lk  ? lock_r :
                          hit_ge  ? {7'h00, gien_r} : RST_BYTE;

  // Fault detection and the 12-bit counter
  wire         fault_act = en_r[EN_FAULT_BIT] & (fault_pin == fp_r);
  wire         run       = en_r[0] | en_r[3];
  wire [3:0]   dmask     = div_mask(clk_a);
  wire         tick      = run & ((pre_r & dmask) == dmask);
  wire         last      = (cnt_r == per_a - 12'h001);
  wire         bound     = tick & ((per_a == 12'h000) | last);
  wire         load      = ~run | bound;
  wire         ovf       = tick & (per_a != 12'h000) & last;
  wire         raw       = (per_a == 12'h000) ? 1'b0 :
                           (per_a <= duty_a)  ? 1'b1 :
                           (cnt_r < duty_a);
  wire         main_wave = raw ^ pol_a;
  wire         inactive  = fault_act | hold_r;
  wire [5:0]   waves     = {~sub_wave[1], ~sub_wave[0], ~main_wave,
                            sub_wave[1], sub_wave[0], main_wave};
  wire [5:0]   live      = en_r[5:0] & en_d2;

  // Next-state terms for flags and the counter
  always_comb begin
    fs_nxt   = fault_act | (fs_r & ~(wr_ctl & ~wdat[CTL_FS_BIT]));
    if_nxt   = ovf | (if_r & ~(wr_ctl & ~wdat[CTL_IF_BIT]));
    hold_nxt = fault_act | (hold_r & (fs_r | ~load));
    cnt_nxt  = load ? 12'h000 : (tick ? cnt_r + 12'h001 : cnt_r);
  end

  // Pin levels: off, forced inactive, or waveform
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pins_nxt.level[i] = ~live[i] ? 1'b0 : (inactive ? pol_a : waves[i]);
    end
    pins_nxt.drive = en_r[5:0];
  end

  // APB answer, one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= setup ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      pslverr_r <= setup & ~mapped;
    end
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r   <= 7'h00;
      {ie_r, fp_r, pol_r} <= 3'h0;
      clk_r  <= 2'h0;
      per_r  <= 12'h000;
      duty_r <= 12'h000;
      lock_r <= RST_BYTE;
      gien_r <= 1'b0;
    end else begin
      if (wr_g & hit_en) en_r <= wdat[6:0];
      if (wr_ctl) begin
        {ie_r, fp_r, pol_r} <= {wdat[CTL_IE_BIT], wdat[CTL_FP_BIT], wdat[CTL_POL_BIT]};
        clk_r <= wdat[1:0];
      end
      if (wr_g & hit_pl) per_r[7:0]   <= wdat;
      if (wr_g & hit_ph) per_r[11:8]  <= wdat[3:0];
      if (wr_g & hit_dl) duty_r[7:0]  <= wdat;
      if (wr_g & hit_dh) duty_r[11:8] <= wdat[3:0];
      if (wr & hit_lk) lock_r <= wdat;
      if (wr & hit_ge) gien_r <= wdat[0];
    end
  end

  // Counter, shadows, flags and enable delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {per_a, duty_a, cnt_r} <= 36'h0;
      {pol_a, clk_a, pre_r} <= 7'h00;
      {fs_r, if_r, hold_r} <= 3'h0;
      {en_d1, en_d2} <= 12'h000;
    end else begin
      pre_r  <= run ? pre_r + 4'h1 : 4'h0;
      cnt_r  <= cnt_nxt;
      if (load) begin
        {per_a, duty_a, pol_a, clk_a} <= {per_r, duty_r, pol_r, clk_r};
      end
      {fs_r, if_r, hold_r} <= {fs_nxt, if_nxt, hold_nxt};
      en_d1  <= en_r[5:0];
      en_d2  <= en_d1;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r      <= '0;
      fault_sel_r <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      pins_r      <= pins_nxt;
      fault_sel_r <= en_r[EN_FAULT_BIT];
      irq_r       <= gien_r & ((ie_r & if_r) | (|sub_irq));
    end
  end

  assign pready    = pready_r;
  assign prdata    = prdata_r;
  assign pslverr   = pslverr_r;
  assign pins      = pins_r;
  assign fault_sel = fault_sel_r;
  assign irq       = irq_r;

  // Checks
  a_lock_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (wr & hit_pl & ~unlocked) |=> $stable(per_r[7:0]))
    else $error("period low changed while locked");
  a_enable_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(en_r[0]) |-> (pins_r.level[0] == 1'b0)[*3])
    else $error("waveform appeared before three clocks");
  a_disable_now: assert property (@(posedge pclk) disable iff (!presetn)
    !en_r[0] |=> pins_r.level[0] == 1'b0)
    else $error("output not stopped after disable");
  a_fault_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_r[EN_FAULT_BIT] && !fs_r) |=> !fs_r)
    else $error("fault status set while detection off");
  a_fault_sets: assert property (@(posedge pclk) disable iff (!presetn)
    fault_act |=> fs_r ##0 hold_r)
    else $error("fault did not set status");
  a_clear_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && !wdat[CTL_FS_BIT] && fault_act) |=> fs_r)
    else $error("fault status cleared during fault");
  a_inactive_level: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_act && live[3]) |=> pins_r.level[3] == $past(pol_a))
    else $error("companion not at inactive level");
  a_period_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (live[0] && !inactive && per_a == 12'h000) |=> pins_r.level[0] == $past(pol_a))
    else $error("zero period output wrong");
  a_overflow_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ovf |=> if_r ##1 (if_r || $past(wr_ctl)))
    else $error("overflow flag not set");
  c_fault_event: cover property (@(posedge pclk) disable iff (!presetn)
    fault_act ##1 fs_r);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf);
  c_pin_rise: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(pins_r.level[0]));
  c_fault_clear: cover property (@(posedge pclk) disable iff (!presetn)
    fs_r ##1 !fs_r);
  c_locked_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr && !unlocked);

  // Pins hand over to the waveform exactly as the enables say
  a_drive_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pins_r.drive == $past(en_r[5:0]))
    else $error("pin ownership does not follow enables");
  // Fault pin use follows the fault-enable bit
  a_fsel_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> fault_sel_r == $past(en_r[EN_FAULT_BIT]))
    else $error("fault pin use does not follow enable");
  // The selected fault level latches the status
  a_fault_level: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r[EN_FAULT_BIT] && fault_pin == fp_r) |=> fs_r)
    else $error("selected fault level not detected");
  // With detection off and nothing pending, pins are never forced
  a_fault_off_pins: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_r[EN_FAULT_BIT] && !hold_r) |=> !hold_r)
    else $error("pins forced while detection off");
  // Every enabled pin past its enable delay takes the inactive level during a fault
  a_all_inactive: assert property (@(posedge pclk) disable iff (!presetn)
    fault_act |=> pins_r.level == ($past(live) & {6{$past(pol_a)}}))
    else $error("pins not all at inactive level");
  // Zero enables silence every pin on the next edge
  a_disable_all: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r[5:0] == 6'h00) |=> pins_r.level == 6'h00)
    else $error("pins not silenced after disable");
  // A cleared status keeps pins forced until the period ends
  a_hold_to_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (hold_r && !fs_r && !fault_act && !load) |=> hold_r)
    else $error("waveform resumed inside a period");
  // At the period start the forced state is released
  a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
    (hold_r && !fs_r && !fault_act && load) |=> !hold_r)
    else $error("waveform not resumed at period start");
  // Prescaler ticks never fall on two edges in a row
  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick)
    else $error("prescaler ticked twice in a row");
  // The counter restarts at each period boundary
  a_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    bound |=> cnt_r == 12'h000)
    else $error("counter not restarted at boundary");
  // One step per tick inside a period
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !load) |=> cnt_r == $past(cnt_r) + 12'h001)
    else $error("counter did not step on tick");
  // No step between ticks
  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !load) |=> $stable(cnt_r))
    else $error("counter moved without tick");
  // Duty portion shows the active level
  a_duty_active: assert property (@(posedge pclk) disable iff (!presetn)
    (live[0] && !inactive && per_a > duty_a && cnt_r < duty_a) |=>
      pins_r.level[0] != $past(pol_a))
    else $error("duty portion not active");
  // The rest of the period shows the inactive level
  a_duty_rest: assert property (@(posedge pclk) disable iff (!presetn)
    (live[0] && !inactive && per_a > duty_a && cnt_r >= duty_a) |=>
      pins_r.level[0] == $past(pol_a))
    else $error("rest of period not inactive");
  // Nonzero period not above duty gives a constant active level
  a_full_active: assert property (@(posedge pclk) disable iff (!presetn)
    (live[0] && !inactive && per_a != 12'h000 && per_a <= duty_a) |=>
      pins_r.level[0] != $past(pol_a))
    else $error("full duty output wrong");
  // Zero period with low-active duty holds the pin high
  a_zero_period_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (live[0] && !inactive && per_a == 12'h000 && pol_a) |=>
      pins_r.level[0])
    else $error("zero period output not high");
  // Shadows move only at a period start or while the counter is stopped
  a_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !load |=> $stable(per_a) && $stable(duty_a) && $stable(pol_a) && $stable(clk_a))
    else $error("settings changed inside a period");
  // Global enable low blocks every request
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !gien_r |=> !irq_r)
    else $error("request without global enable");
  // Enabled and flagged main channel requests
  a_irq_main: assert property (@(posedge pclk) disable iff (!presetn)
    (gien_r && ie_r && if_r) |=> irq_r)
    else $error("main channel request missing");
  // The 8-bit channels share the same request line
  a_irq_shared: assert property (@(posedge pclk) disable iff (!presetn)
    (gien_r && (|sub_irq)) |=> irq_r)
    else $error("shared request missing");
  // Overflow wins over a clearing write
  a_flag_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && wr_ctl) |=> if_r)
    else $error("overflow lost to clear");
  // Companion sits opposite its main output
  a_companion_inv: assert property (@(posedge pclk) disable iff (!presetn)
    (live[0] && live[3] && !inactive) |=> pins_r.level[0] != pins_r.level[3])
    else $error("companion not opposite main");
  // Lock key is always writable
  a_lock_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_lk) |=> lock_r == $past(wdat))
    else $error("lock key write lost");
  // Locked enables keep their contents
  a_locked_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_en && !unlocked) |=> $stable(en_r))
    else $error("enables changed while locked");
  // Locked control keeps its contents
  a_locked_control: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_ctl && !unlocked) |=> $stable({ie_r, fp_r, pol_r, clk_r}))
    else $error("control changed while locked");
  // Bus answer lasts one cycle
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_r |=> !pready_r)
    else $error("ready held longer than one cycle");
  // Error only comes with the answer
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_r |-> pready_r)
    else $error("error without ready");
  // Read data is zero outside the answer
  a_idle_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    !pready_r |-> prdata_r == 32'h0000_0000)
    else $error("read data outside answer");
endmodule

// ===== sim/pfl_partner.sv
`timescale 1ns/1ns
// Fault sensor: shows the fault level while commanded, the opposite level otherwise
module pfl_partner (
  input  wire logic pclk,
  input  wire logic fault_act,
  input  wire logic fault_hi,
  output logic      fault_pin
);
  // The pin has no pull-up, so the sensor always drives a defined level
  always_ff @(posedge pclk) begin
    fault_pin <= fault_act ? fault_hi : ~fault_hi;
  end
endmodule

// ===== sim/pfl_top_tb.sv
`timescale 1ns/1ns
module pfl_top_tb;
  import pfl_pkg::*;
  logic         pclk;
  logic         presetn;
  pfl_apb_req_t req;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic         perr;
  logic         fault_pin;
  logic         fault_act;
  logic         fault_hi;
  logic [1:0]   sub_wave;
  logic [1:0]   sub_irq;
  pfl_pins_t    pins;
  logic         fault_sel;
  logic         irq;
  logic [31:0]  rd;
  int           bad_count;
  int           cmp_count;
  int           ones;
  int           rises;

  pfl_top i_pfl_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .fault_pin(fault_pin), .sub_wave(sub_wave),
    .sub_irq(sub_irq), .pins(pins), .fault_sel(fault_sel), .irq(irq));
  pfl_partner i_pfl_partner (.pclk(pclk), .fault_act(fault_act), .fault_hi(fault_hi),
    .fault_pin(fault_pin));

  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= reg_addr(idx);
    req.pwdata <= {24'h000000, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) bad_count++;
    rd = prdata;
    perr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd & {24'h000000, m}, {24'h000000, e});
  endtask

  // Counts high samples and rising edges of one pin over 128 cycles
  task automatic meas(input int b);
    logic prev;
    repeat (40) @(posedge pclk);
    prev = pins.level[b];
    ones = 0;
    rises = 0;
    repeat (128) begin
      @(posedge pclk);
      ones += (pins.level[b] === 1'b1);
      rises += (pins.level[b] === 1'b1 && prev === 1'b0);
      prev = pins.level[b];
    end
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    req = '0;
    fault_act = 1'b0;
    fault_hi = 1'b0;
    sub_wave = 2'h0;
    sub_irq = 2'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_ENABLE, 8'hFF, 8'h00);
    rdc(IDX_CONTROL, 8'hFF, 8'h00);
    rdc(IDX_LOCK, 8'hFF, 8'h00);
    wr(IDX_ENABLE, 8'h01);
    rdc(IDX_ENABLE, 8'hFF, 8'h00);
    wr(IDX_LOCK, LOCK_KEY);
    rdc(IDX_LOCK, 8'hFF, 8'h55);
    apb(1'b0, 8'h10, 8'h00);
    chk(perr, 1'b1);
    wr(IDX_PER_LO, 8'h02);
    wr(IDX_PER_HI, 8'h00);
    wr(IDX_DUTY_LO, 8'h01);
    wr(IDX_DUTY_HI, 8'h00);
    wr(IDX_ENABLE, 8'h01);
    @(negedge pclk);
    chk(pins.drive, 6'h01);
    @(posedge pclk);
    // Every clock divider: half duty, rise count halves with each larger divider
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CONTROL, 8'(s));
      meas(0);
      chk(ones, 64);
      chk(rises, 32 >> s);
    end
    rdc(IDX_CONTROL, 8'h40, 8'h40);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_PER_LO, 8'h04);
    wr(IDX_ENABLE, 8'h09);
    meas(0);
    chk(ones, 32);
    meas(3);
    chk(ones, 96);
    wr(IDX_CONTROL, 8'h04);
    meas(0);
    chk(ones, 96);
    wr(IDX_PER_LO, 8'h00);
    meas(0);
    chk(ones, 128);
    wr(IDX_CONTROL, 8'h00);
    meas(0);
    chk(ones, 0);
    wr(IDX_PER_LO, 8'h02);
    wr(IDX_DUTY_LO, 8'h03);
    meas(0);
    chk(ones, 128);
    wr(IDX_DUTY_LO, 8'h01);
    // Fault handling for both fault polarities
    for (int f = 0; f < 2; f++) begin
      fault_hi <= f[0];
      fault_act <= 1'b1;
      wr(IDX_ENABLE, 8'h01);
      wr(IDX_CONTROL, {4'h0, f[0], 3'h0});
      meas(0);
      chk(ones, 64);
      wr(IDX_ENABLE, 8'h41);
      @(negedge pclk);
      chk(fault_sel, 1'b1);
      @(posedge pclk);
      meas(0);
      chk(ones, 0);
      rdc(IDX_CONTROL, 8'h10, 8'h10);
      wr(IDX_CONTROL, {4'h0, f[0], 3'h0});
      rdc(IDX_CONTROL, 8'h10, 8'h10);
      fault_act <= 1'b0;
      wr(IDX_CONTROL, {4'h0, f[0], 3'h0});
      rdc(IDX_CONTROL, 8'h10, 8'h00);
      meas(0);
      chk(ones, 64);
    end
    // Shared request: main flag path, then an 8-bit channel request alone
    wr(IDX_GIEN, 8'h01);
    wr(IDX_CONTROL, 8'h88);
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    chk(irq, 1'b1);
    @(posedge pclk);
    wr(IDX_CONTROL, 8'h08);
    sub_irq <= 2'h2;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(irq, 1'b1);
    @(posedge pclk);
    sub_irq <= 2'h0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(irq, 1'b0);
    @(posedge pclk);
    wr(IDX_ENABLE, 8'h00);
    @(negedge pclk);
    chk({pins.drive, pins.level}, 12'h000);
    @(posedge pclk);
    wr(IDX_LOCK, 8'h00);
    wr(IDX_PER_LO, 8'h07);
    rdc(IDX_PER_LO, 8'hFF, 8'h02);
    wr(IDX_ENABLE, 8'h3F);
    rdc(IDX_ENABLE, 8'hFF, 8'h00);
    final_report();
  end
endmodule
